// ---- ldsp_decoder.sv ----
// What this block does
// - an input beat is taken only when ready and valid are both high
// - low input valid pauses consumption; it resumes when valid returns
// - ready latency zero: beat offered while ready is high is taken then
// - output data holds steady while the sink holds ready low
// - output bits above the first core's maximum lifting size read zero
// - output mode, tag, sizes, count and flag valid on the start beat
// - output tag equals the tag of the matching input block
// - a 14-bit output gives block size K in bits
// - a 9-bit output gives lifting size; only that many low bits matter
// - iteration count starts at 0, stays below the block's limit
// - early stop flag is 1 on termination, may be 1 on last pass
// - each input beat carries 64 soft values of 5 or 6 bits
// - first 2*Z code bits are punctured and filled with zero values
// - a block takes (n_b - 2) * ceil(Z / 64) input beats
// - soft values are two's complement, most negative code accepted
// - positive values decide 0, zero and negative decide 1
// - output mode equals the mode given with the input block
// - output ready latency zero; low ready applies back-pressure
// - mode bit 11 base graph, 10:8 rate, 7 syndrome, 6 no-stop, 5:0 Z
// - output 22 beats for graph one, 10 for graph two, Z low bits each
// - reset is synchronous; one cycle held is enough
// - blocks leave in the order they were accepted
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "ldsp_regs.svh"
module ldsp_decoder #(
  parameter int IN_WIDTH               = 6,
  parameter int FIRST_CORE_MAX_LIFTING = 384
) (
  input  wire logic                      i_mclk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [7:0]                i_wb_adr,
  input  wire logic [3:0]                i_wb_sel,
  input  wire logic [31:0]               i_wb_dat,
  output logic      [31:0]               o_wb_dat,
  output logic                           o_wb_ack,
  input  wire logic                      i_in_valid,
  input  wire logic                      i_in_sop,
  input  wire logic                      i_in_eop,
  output logic                           o_in_ready,
  input  wire logic [64*IN_WIDTH-1:0]    i_in_data,
  input  wire logic [11:0]               i_in_mode,
  input  wire logic [7:0]                i_in_tag,
  input  wire logic [5:0]                i_in_max_iter,
  output logic                           o_out_valid,
  output logic                           o_out_sop,
  output logic                           o_out_eop,
  input  wire logic                      i_out_ready,
  output logic      [383:0]              o_out_data,
  output logic      [11:0]               o_out_mode,
  output logic      [7:0]                o_out_tag,
  output logic      [13:0]               o_out_blk_k,
  output logic      [8:0]                o_out_blk_z,
  output logic      [5:0]                o_out_iter,
  output logic                           o_out_early_stop_flag
);
  localparam int LANES = `LDSP_LANES;

  function automatic logic [8:0] lift(input logic [5:0] idx);
    case (idx)
      6'h00: lift = 9'h002;
      6'h01: lift = 9'h003;
      6'h02: lift = 9'h004;
      6'h03: lift = 9'h005;
      6'h04: lift = 9'h006;
      6'h05: lift = 9'h007;
      6'h06: lift = 9'h008;
      6'h07: lift = 9'h009;
      6'h08: lift = 9'h00A;
      6'h09: lift = 9'h00B;
      6'h0A: lift = 9'h00C;
      6'h0B: lift = 9'h00D;
      6'h0C: lift = 9'h00E;
      6'h0D: lift = 9'h00F;
      6'h0E: lift = 9'h010;
      6'h0F: lift = 9'h012;
      6'h10: lift = 9'h014;
      6'h11: lift = 9'h016;
      6'h12: lift = 9'h018;
      6'h13: lift = 9'h01A;
      6'h14: lift = 9'h01C;
      6'h15: lift = 9'h01E;
      6'h16: lift = 9'h020;
      6'h17: lift = 9'h024;
      6'h18: lift = 9'h028;
      6'h19: lift = 9'h02C;
      6'h1A: lift = 9'h030;
      6'h1B: lift = 9'h034;
      6'h1C: lift = 9'h038;
      6'h1D: lift = 9'h03C;
      6'h1E: lift = 9'h040;
      6'h1F: lift = 9'h048;
      6'h20: lift = 9'h050;
      6'h21: lift = 9'h058;
      6'h22: lift = 9'h060;
      6'h23: lift = 9'h068;
      6'h24: lift = 9'h070;
      6'h25: lift = 9'h078;
      6'h26: lift = 9'h080;
      6'h27: lift = 9'h090;
      6'h28: lift = 9'h0A0;
      6'h29: lift = 9'h0B0;
      6'h2A: lift = 9'h0C0;
      6'h2B: lift = 9'h0D0;
      6'h2C: lift = 9'h0E0;
      6'h2D: lift = 9'h0F0;
      6'h2E: lift = 9'h100;
      6'h2F: lift = 9'h120;
      6'h30: lift = 9'h140;
      6'h31: lift = 9'h160;
      6'h32: lift = 9'h180;
      default: lift = 9'h002;
    endcase
  endfunction

  // parity check columns; the unlisted graph-one rate 0 falls back to 27 columns, the shortest graph-one entry
  function automatic logic [6:0] ncol(input logic bg2, input logic [2:0] rate);
    case ({bg2, rate})
      4'h1: ncol = 7'h44;
      4'h2: ncol = 7'h39;
      4'h3: ncol = 7'h2E;
      4'h4: ncol = 7'h23;
      4'h5: ncol = 7'h20;
      4'h6: ncol = 7'h1D;
      4'h7: ncol = 7'h1B;
      4'h8: ncol = 7'h34;
      4'h9: ncol = 7'h20;
      4'hA: ncol = 7'h1B;
      4'hB: ncol = 7'h16;
      4'hC: ncol = 7'h11;
      4'hD: ncol = 7'h11;
      4'hE: ncol = 7'h11;
      4'hF: ncol = 7'h11;
      default: ncol = 7'h1B;
    endcase
  endfunction

  function automatic logic [4:0] kbase(input logic bg2);
    kbase = bg2 ? `LDSP_KB_BG2 : `LDSP_KB_BG1;
  endfunction

  function automatic logic [383:0] zmask(input logic [8:0] z);
    zmask = ~({384{1'b1}} << z);
  endfunction

  ldsp_pkg::ldsp_state_type state;
  ldsp_pkg::ldsp_state_type next_state;
  logic [383:0]  msg_mem [0:21];
  logic [LANES-1:0] hard;
  logic [11:0]   blk_mode;
  logic [7:0]    blk_tag;
  logic [5:0]    blk_lim;
  logic [2:0]    rx_sub;
  logic [6:0]    rx_grp;
  logic [4:0]    tx_idx;
  logic          ctrl_en;
  logic [15:0]   blk_cnt;
  logic [11:0]   eff_mode;
  logic [8:0]    eff_z;
  logic [2:0]    bpg;
  logic [6:0]    ngrp;
  logic [6:0]    col;
  logic          acc;
  logic          wr_en;
  logic          last_beat;
  logic          ld;
  logic          out_done;
  logic [4:0]    kb_o;
  logic          wb_req;

  // hard decisions straight from the sign; zero counts as a one
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_hard
      logic [IN_WIDTH-1:0] llr;
      assign llr = i_in_data[l*IN_WIDTH +: IN_WIDTH];
      assign hard[l] = llr[IN_WIDTH-1] | (llr == '0);
    end
  endgenerate

  assign acc       = o_in_ready & i_in_valid;
  assign eff_mode  = (state == ldsp_pkg::ST_IDLE) ? i_in_mode : blk_mode;
  assign eff_z     = lift(eff_mode[5:0]);
  assign bpg       = 3'((10'(eff_z) + 10'h03F) >> 6);
  assign ngrp      = ncol(eff_mode[`LDSP_MODE_BG_BIT], eff_mode[10:8]) - `LDSP_PUNCT_COLS;
  assign col       = rx_grp + `LDSP_PUNCT_COLS;
  assign wr_en     = acc & ((state == ldsp_pkg::ST_RECV) | ((state == ldsp_pkg::ST_IDLE) & i_in_sop));
  assign last_beat = (rx_sub == bpg - 3'h1) && (rx_grp == ngrp - 7'h01);
  assign kb_o      = kbase(blk_mode[`LDSP_MODE_BG_BIT]);
  assign ld        = (state == ldsp_pkg::ST_SEND) && (tx_idx < kb_o) && (!o_out_valid || i_out_ready);
  assign out_done  = o_out_valid & i_out_ready & o_out_eop;
  assign wb_req    = i_wb_cyc & i_wb_stb;

  // one block buffer, so blocks can never overtake each other
  always_comb begin
    next_state = state;
    case (state)
      ldsp_pkg::ST_IDLE: begin
        if (wr_en) begin
          next_state = last_beat ? ldsp_pkg::ST_SEND : ldsp_pkg::ST_RECV;
        end
      end
      ldsp_pkg::ST_RECV: begin
        if (wr_en && last_beat) begin
          next_state = ldsp_pkg::ST_SEND;
        end
      end
      ldsp_pkg::ST_SEND: begin
        if (out_done) begin
          next_state = ldsp_pkg::ST_IDLE;
        end
      end
      default: next_state = ldsp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state <= ldsp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ready is registered from the next state; the handshake still has zero latency
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_in_ready <= 1'b0;
    end else begin
      o_in_ready <= ctrl_en && (next_state != ldsp_pkg::ST_SEND);
    end
  end

  // end flag is not trusted; the beat count closes the block
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rx_sub <= 3'h0;
      rx_grp <= 7'h00;
    end else if (wr_en) begin
      if (last_beat) begin
        rx_sub <= 3'h0;
        rx_grp <= 7'h00;
      end else if (rx_sub == bpg - 3'h1) begin
        rx_sub <= 3'h0;
        rx_grp <= rx_grp + 7'h01;
      end else begin
        rx_sub <= rx_sub + 3'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      blk_mode <= 12'h000;
      blk_tag  <= 8'h00;
      blk_lim  <= 6'h00;
    end else if (wr_en && state == ldsp_pkg::ST_IDLE) begin
      blk_mode <= i_in_mode;
      blk_tag  <= i_in_tag;
      blk_lim  <= i_in_max_iter;
    end
  end

  // only message columns are kept; parity beats are counted and dropped
  always_ff @(posedge i_mclk) begin
    if (wr_en) begin
      if (state == ldsp_pkg::ST_IDLE) begin
        msg_mem[0] <= {384{1'b1}};
        msg_mem[1] <= {384{1'b1}};
      end
      if (col < 7'(kbase(eff_mode[`LDSP_MODE_BG_BIT]))) begin
        msg_mem[col[4:0]][{rx_sub, 6'h00} +: LANES] <= hard;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_out_valid <= 1'b0;
      o_out_sop   <= 1'b0;
      o_out_eop   <= 1'b0;
      o_out_data  <= 384'h0;
      tx_idx      <= 5'h00;
    end else if (ld) begin
      o_out_valid <= 1'b1;
      o_out_sop   <= (tx_idx == 5'h00);
      o_out_eop   <= (tx_idx == kb_o - 5'h01);
      o_out_data  <= msg_mem[tx_idx] & zmask(lift(blk_mode[5:0])) & zmask(9'(FIRST_CORE_MAX_LIFTING));
      tx_idx      <= tx_idx + 5'h01;
    end else begin
      if (o_out_valid && i_out_ready) begin
        o_out_valid <= 1'b0;
        o_out_sop   <= 1'b0;
        o_out_eop   <= 1'b0;
      end
      if (state != ldsp_pkg::ST_SEND) begin
        tx_idx <= 5'h00;
      end
    end
  end

  // hard decision pass only, so the count is always the first iteration
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_out_mode            <= 12'h000;
      o_out_tag             <= 8'h00;
      o_out_blk_k           <= 14'h0000;
      o_out_blk_z           <= 9'h000;
      o_out_iter            <= 6'h00;
      o_out_early_stop_flag <= 1'b0;
    end else if (ld && tx_idx == 5'h00) begin
      o_out_mode            <= blk_mode;
      o_out_tag             <= blk_tag;
      o_out_blk_k           <= 14'(kb_o) * 14'(lift(blk_mode[5:0]));
      o_out_blk_z           <= lift(blk_mode[5:0]);
      o_out_iter            <= 6'h00;
      o_out_early_stop_flag <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      blk_cnt <= 16'h0000;
    end else if (out_done) begin
      blk_cnt <= blk_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_en <= 1'(`LDSP_CTRL_RST);
    end else if (wb_req && i_wb_we && o_wb_ack && i_wb_sel[0] && i_wb_adr == `LDSP_CTRL_OFS) begin
      ctrl_en <= i_wb_dat[`LDSP_CTRL_EN_BIT];
    end
  end

  // unmapped addresses ack with zero data
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req & ~o_wb_ack;
      if (wb_req && !o_wb_ack) begin
        case (i_wb_adr)
          `LDSP_CTRL_OFS: o_wb_dat <= {31'h0, ctrl_en};
          `LDSP_STAT_OFS: o_wb_dat <= {blk_cnt, 5'h00, tx_idx, state, 1'b0, i_in_eop, o_in_ready};
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  logic [4:0] chk_beats;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || out_done) begin
      chk_beats <= 5'h00;
    end else if (o_out_valid && i_out_ready) begin
      chk_beats <= chk_beats + 5'h01;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  hold_out_data_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
    else $error("output data moved under back-pressure");
  take_on_hs_a: assert property ((state == ldsp_pkg::ST_RECV) && !acc |=> $stable(rx_sub) && $stable(rx_grp))
    else $error("input progressed without handshake");
  take_now_a: assert property ((state == ldsp_pkg::ST_RECV) && acc && !last_beat |=> !$stable({rx_grp, rx_sub}))
    else $error("offered beat not taken in its cycle");
  upper_zero_a: assert property (o_out_valid |-> (o_out_data & ~zmask(9'(FIRST_CORE_MAX_LIFTING))) == 384'h0)
    else $error("bits above max lifting not zero");
  low_z_a: assert property (o_out_valid |-> (o_out_data & ~zmask(o_out_blk_z)) == 384'h0)
    else $error("bits above Z not zero");
  tag_pair_a: assert property (wr_en && state == ldsp_pkg::ST_IDLE |=> blk_tag == $past(i_in_tag))
    else $error("tag not captured with block");
  blk_size_a: assert property (o_out_valid && o_out_sop |-> o_out_blk_k == 14'(kbase(o_out_mode[11])) * 14'(o_out_blk_z))
    else $error("block size does not match mode");
  iter_lim_a: assert property (o_out_valid && o_out_sop && blk_lim != 6'h00 |-> o_out_iter < blk_lim)
    else $error("iteration count at or above limit");
  beat_count_a: assert property (out_done |-> chk_beats == kbase(o_out_mode[11]) - 5'h01)
    else $error("wrong number of output beats");
  eop_end_a: assert property (out_done |=> !o_out_valid ##1 !o_out_valid)
    else $error("output continued after end beat");
endmodule

// ---- ldsp_regs.svh ----
`ifndef LDSP_REGS_SVH
`define LDSP_REGS_SVH
`define LDSP_CTRL_OFS    8'h00
`define LDSP_STAT_OFS    8'h04
`define LDSP_CTRL_EN_BIT 0
`define LDSP_CTRL_RST    32'h0000_0001
`define LDSP_LANES       64
`define LDSP_OUT_W       384
`define LDSP_KB_BG1      5'h16
`define LDSP_KB_BG2      5'h0A
`define LDSP_PUNCT_COLS  7'h02
`define LDSP_MODE_BG_BIT 11
`endif

// ---- ldsp_pkg.sv ----
package ldsp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RECV = 3'b010,
    ST_SEND = 3'b100
  } ldsp_state_type;
endpackage

// ---- ldsp_stream_partner.sv ----
`timescale 1ns/10ps
module ldsp_stream_partner (
  input  wire logic         i_mclk,
  input  wire logic         i_stall,
  input  wire logic         i_in_ready,
  output logic              o_in_valid,
  output logic              o_in_sop,
  output logic              o_in_eop,
  output logic [383:0]      o_in_data,
  output logic [11:0]       o_in_mode,
  output logic [7:0]        o_in_tag,
  output logic [5:0]        o_in_max_iter,
  input  wire logic [435:0] i_out_beat,
  input  wire logic         i_out_valid,
  output logic              o_out_ready
);
  logic [435:0] beat_q[$];
  logic [383:0] held;
  logic         hold_pend;
  logic [1:0]   stall_cnt;
  int           err;

  initial begin
    {o_in_valid, o_in_sop, o_in_eop, o_out_ready, hold_pend} = 5'h00;
    {o_in_data, o_in_mode, o_in_tag, o_in_max_iter, held} = '0;
    stall_cnt = 2'h0;
    err = 0;
  end

  // spread over the full range, most negative code included
  function automatic logic [5:0] llr(input int g, input int i);
    case ((g * 3 + i) % 5)
      0: return 6'h1F;
      1: return 6'h01;
      2: return 6'h00;
      3: return 6'h3F;
      default: return 6'h20;
    endcase
  endfunction

  // sideband only true on the start beat, inverted elsewhere to catch late sampling
  task automatic send_block(input logic [11:0] mode, input logic [7:0] tag, input logic [5:0] lim,
                            input int z, input int beats, input bit gaps);
    int cpg;
    int n;
    cpg = (z + 63) / 64;
    for (int b = 0; b < beats; b++) begin
      if (gaps && b % 2 == 1) begin
        o_in_valid <= 1'b0;
        o_in_data <= ~o_in_data;
        @(posedge i_mclk);
      end
      o_in_valid <= 1'b1;
      o_in_sop <= (b == 0);
      o_in_eop <= (b == beats - 1);
      o_in_mode <= (b == 0) ? mode : ~mode;
      o_in_tag <= (b == 0) ? tag : ~tag;
      o_in_max_iter <= (b == 0) ? lim : ~lim;
      for (int l = 0; l < 64; l++)
        o_in_data[l*6 +: 6] <= ((b % cpg) * 64 + l < z) ? llr(b / cpg, (b % cpg) * 64 + l) : 6'h2A;
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (i_in_ready !== 1'b1 && n < 3000);
      if (n >= 3000)
        err++;
    end
    o_in_valid <= 1'b0;
    o_in_sop <= 1'b0;
    o_in_eop <= 1'b0;
    o_in_data <= ~o_in_data;
    // one idle cycle, so the next block never re-drives valid in the same step
    @(posedge i_mclk);
  endtask

  // stalling sink: ready low two cycles of four when asked
  always @(posedge i_mclk) begin
    stall_cnt <= stall_cnt + 2'h1;
    o_out_ready <= !i_stall || stall_cnt[1];
    if (i_out_valid && o_out_ready)
      beat_q.push_back(i_out_beat);
    if (hold_pend && i_out_beat[383:0] !== held)
      err++;
    hold_pend <= i_out_valid && !o_out_ready;
    held <= i_out_beat[383:0];
  end
endmodule

// ---- tb_ldpc_decoder_stream_ports.sv ----
`timescale 1ns/10ps
module tb_ldpc_decoder_stream_ports;
  logic          i_mclk, i_sys_rst, stall;
  logic          wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]    wb_adr;
  logic [31:0]   wb_wdat, wb_rdat, rd;
  logic          in_valid, in_sop, in_eop, in_ready;
  logic [383:0]  in_data, out_data;
  logic [11:0]   in_mode, out_mode;
  logic [7:0]    in_tag, out_tag;
  logic [5:0]    in_iter, out_iter;
  logic          out_valid, out_sop, out_eop, out_ready, out_flag;
  logic [13:0]   out_k;
  logic [8:0]    out_z;
  int            error_cnt = 0;
  int            total_checks = 0;

  initial i_mclk = 1'b0;
  always #25 i_mclk = ~i_mclk;

  ldsp_decoder #(.IN_WIDTH(6), .FIRST_CORE_MAX_LIFTING(128)) dut_u (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
    .i_wb_adr(wb_adr), .i_wb_sel(4'hF), .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
    .i_in_valid(in_valid), .i_in_sop(in_sop), .i_in_eop(in_eop), .o_in_ready(in_ready),
    .i_in_data(in_data), .i_in_mode(in_mode), .i_in_tag(in_tag), .i_in_max_iter(in_iter),
    .o_out_valid(out_valid), .o_out_sop(out_sop), .o_out_eop(out_eop), .i_out_ready(out_ready),
    .o_out_data(out_data), .o_out_mode(out_mode), .o_out_tag(out_tag), .o_out_blk_k(out_k),
    .o_out_blk_z(out_z), .o_out_iter(out_iter), .o_out_early_stop_flag(out_flag));

  ldsp_stream_partner partner_u (
    .i_mclk(i_mclk), .i_stall(stall), .i_in_ready(in_ready), .o_in_valid(in_valid),
    .o_in_sop(in_sop), .o_in_eop(in_eop), .o_in_data(in_data), .o_in_mode(in_mode),
    .o_in_tag(in_tag), .o_in_max_iter(in_iter), .i_out_valid(out_valid), .o_out_ready(out_ready),
    .i_out_beat({out_sop, out_eop, out_mode, out_tag, out_k, out_z, out_iter, out_flag, out_data}));

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [383:0] got, input logic [383:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      give_verdict();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge i_mclk);
  endtask

  // columns 0 and 1 are the punctured zero values, so they decide 1
  task automatic check_block(input logic [11:0] mode, input logic [7:0] tag, input logic [5:0] lim,
                             input int z, input int kb);
    logic [435:0] bt;
    logic [383:0] ex;
    logic [5:0]   v;
    int           n;
    for (int c = 0; c < kb; c++) begin
      n = 0;
      while (partner_u.beat_q.size() == 0 && n < 3000) begin
        @(posedge i_mclk);
        n++;
      end
      if (n >= 3000) begin
        error_cnt++;
        give_verdict();
      end
      bt = partner_u.beat_q.pop_front();
      ex = '0;
      for (int i = 0; i < z && i < 128; i++) begin
        v = partner_u.llr(c - 2, i);
        ex[i] = (c < 2) || v[5] || v == 6'h00;
      end
      chk(bt[383:0], ex, "output data");
      chk(384'(bt[435:434]), 384'({c == 0, c == kb - 1}), "frame marks");
      if (c == 0) begin
        chk(384'(bt[433:384]), 384'({mode, tag, 14'(kb * z), 9'(z), 6'h00, 1'b1}), "sideband");
        chk(384'(bt[390:385] < lim), 384'(1), "iteration count");
      end
    end
  endtask

  initial begin
    i_sys_rst = 1'b1;
    {stall, wb_cyc, wb_stb, wb_we} = 4'h0;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    wb(1'b0, 8'h00, 32'h0);
    chk(384'(rd), 384'(32'h1), "control reset value");
    wb(1'b0, 8'h04, 32'h0);
    chk(384'({rd[5:3], rd[0]}), 384'(4'b0011), "idle status");
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk(384'(rd), 384'(0), "unmapped read");
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk(384'({rd[0], in_ready}), 384'(0), "input disabled");
    wb(1'b1, 8'h00, 32'h1);
    // back to back: later blocks wait on ready while earlier ones drain
    fork
      begin
        partner_u.send_block(12'hB00, 8'h5A, 6'h01, 2, 20, 1'b1);
        partner_u.send_block(12'h7DE, 8'hA5, 6'h3F, 64, 25, 1'b0);
        partner_u.send_block(12'hC2A, 8'h3C, 6'h0A, 192, 45, 1'b1);
      end
    join_none
    check_block(12'hB00, 8'h5A, 6'h01, 2, 10);
    stall <= 1'b1;
    check_block(12'h7DE, 8'hA5, 6'h3F, 64, 22);
    check_block(12'hC2A, 8'h3C, 6'h0A, 192, 10);
    chk(384'(partner_u.err), 384'(0), "held output or input wait");
    wb(1'b0, 8'h04, 32'h0);
    chk(384'({rd[31:16], rd[5:3]}), 384'({16'h0003, 3'b001}), "blocks sent");
    wb(1'b1, 8'h00, 32'h0);
    // a single reset cycle in mid-run brings back enable, idle and a zero count
    i_sys_rst <= 1'b1;
    @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    wb(1'b0, 8'h04, 32'h0);
    chk(384'(rd), 384'(32'h0000_0009), "status after short reset");
    wb(1'b0, 8'h00, 32'h0);
    chk(384'(rd), 384'(32'h1), "enable after short reset");
    give_verdict();
  end
endmodule
